// File: gyo_defs.svh
// Offsets, field positions, reset values and masks of the gyro config bank
`ifndef GYO_DEFS_SVH
`define GYO_DEFS_SVH

`define GYO_ADDR_DSP3 8'h03
`define GYO_ADDR_SOFT_RST 8'h09
`define GYO_ADDR_RATE_CTRL 8'h0B
`define GYO_ADDR_ZERO_CAL 8'h0C
`define GYO_ADDR_TEMP_FMT 8'h1C
`define GYO_ADDR_SER_IF 8'h1F

`define GYO_RST_DSP3 8'h00
`define GYO_RST_RATE_CTRL 8'h01
`define GYO_RST_TEMP_FMT 8'h4B
`define GYO_RST_SER_IF 8'h01

`define GYO_RW_DSP3 8'h67
`define GYO_RW_RATE_CTRL 8'h3F
`define GYO_RW_TEMP_FMT 8'h7F
`define GYO_RW_SER_IF 8'h03

`define GYO_BIT_ZERO_CAL_EN 6
`define GYO_BIT_RATE_WIDTH 2
`define GYO_TEMP_WIDTH_HI 6
`define GYO_TEMP_WIDTH_LO 5
`define GYO_SDO_SEL_HI 3
`define GYO_SDO_SEL_LO 2
`define GYO_BIT_SPI_WIRE 1
`define GYO_BIT_I2C_EN 0
`define GYO_SPI_WIRE_MASK 8'h02
`define GYO_TEMP_WIDTH_BAD 2'h3

`define GYO_RATE_W 24
`define GYO_RATE_ZERO 24'h000000
`define GYO_BYTE_ZERO 8'h00

`endif

// File: gyo_pkg.sv
// Types shared by the gyro config bank
package gyo_pkg;

  typedef enum logic {
    GYO_CAL_IDLE = 1'b0,
    GYO_CAL_APPLY = 1'b1
  } gyo_cal_state_t;

endpackage

// File: gyo_zero_cal.sv
// Zero-rate offset capture and subtraction
`timescale 1ns/1ps
`include "gyo_defs.svh"

module gyo_zero_cal (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Control
  input wire logic cal_cmd_in,
  input wire logic cal_enable_in,
  input wire logic cal_variant_in,
  input wire logic clear_in,
  // Rate path
  input wire logic [`GYO_RATE_W-1:0] raw_rate_in,
  output logic [`GYO_RATE_W-1:0] rate_out,
  output logic cal_applied_out
);

  gyo_pkg::gyo_cal_state_t state_q;
  gyo_pkg::gyo_cal_state_t state_d;
  logic [`GYO_RATE_W-1:0] offset_q;
  logic [`GYO_RATE_W-1:0] offset_d;
  logic [`GYO_RATE_W-1:0] rate_q;
  logic [`GYO_RATE_W-1:0] rate_d;

  always_comb begin
    state_d = state_q;
    offset_d = offset_q;
    case (state_q)
      gyo_pkg::GYO_CAL_IDLE: begin
        // Sample taken in the command cycle itself
        if (cal_cmd_in && cal_enable_in && cal_variant_in) begin
          offset_d = raw_rate_in;
          state_d = gyo_pkg::GYO_CAL_APPLY;
        end
      end
      gyo_pkg::GYO_CAL_APPLY: begin
        if (cal_cmd_in && cal_enable_in && cal_variant_in) begin
          offset_d = raw_rate_in;
        end
        if (!cal_enable_in) begin
          state_d = gyo_pkg::GYO_CAL_IDLE;
        end
      end
      default: state_d = gyo_pkg::GYO_CAL_IDLE;
    endcase
    if (clear_in) begin
      state_d = gyo_pkg::GYO_CAL_IDLE;
      offset_d = `GYO_RATE_ZERO;
    end
    if (state_q == gyo_pkg::GYO_CAL_APPLY && cal_enable_in) begin
      rate_d = raw_rate_in - offset_q;
    end else begin
      rate_d = raw_rate_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= gyo_pkg::GYO_CAL_IDLE;
      offset_q <= `GYO_RATE_ZERO;
      rate_q <= `GYO_RATE_ZERO;
    end else begin
      state_q <= state_d;
      offset_q <= offset_d;
      rate_q <= rate_d;
    end
  end

  assign rate_out = rate_q;
  assign cal_applied_out = (state_q == gyo_pkg::GYO_CAL_APPLY);

endmodule

// File: gyo_cfg_regs.sv
// Gyro output and interface configuration register bank
`timescale 1ns/1ps
`include "gyo_defs.svh"

module gyo_cfg_regs (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Command port from the serial front end
  input wire logic txn_valid_in,
  input wire logic [7:0] txn_addr_in,
  input wire logic txn_write_in,
  input wire logic txn_has_data_in,
  input wire logic [7:0] txn_wdata_in,
  input wire logic txn_from_spi_in,
  output logic [7:0] rd_data_out,
  // Factory straps
  input wire logic multi_slave_en_in,
  input wire logic cal_variant_in,
  // Rate path
  input wire logic [`GYO_RATE_W-1:0] raw_rate_in,
  output logic [`GYO_RATE_W-1:0] rate_out,
  output logic cal_applied_out,
  // Configuration outputs
  output logic rate_word_width_sel_out,
  output logic [1:0] temp_word_width_sel_out,
  output logic [1:0] sdo_pin_function_sel_out,
  output logic spi_wire_count_sel_out,
  output logic i2c_enable_out,
  output logic zero_cal_enable_out
);

  logic [7:0] dsp3_q;
  logic [7:0] dsp3_d;
  logic [7:0] rate_ctrl_q;
  logic [7:0] rate_ctrl_d;
  logic [7:0] temp_fmt_q;
  logic [7:0] temp_fmt_d;
  logic [7:0] ser_if_q;
  logic [7:0] ser_if_d;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic wr;
  logic rd;
  logic cmd;
  logic soft_rst;
  logic cal_cmd;
  logic [7:0] ser_mask;

  // Only writable bits take data; read-only bits keep their value
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] wdata,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (wdata & mask);
  endfunction

  assign wr = txn_valid_in && txn_write_in && txn_has_data_in;
  assign rd = txn_valid_in && !txn_write_in && txn_has_data_in;
  assign cmd = txn_valid_in && !txn_has_data_in;
  assign soft_rst = cmd && (txn_addr_in == `GYO_ADDR_SOFT_RST);
  assign cal_cmd = cmd && (txn_addr_in == `GYO_ADDR_ZERO_CAL);

  always_comb begin
    dsp3_d = dsp3_q;
    rate_ctrl_d = rate_ctrl_q;
    temp_fmt_d = temp_fmt_q;
    ser_if_d = ser_if_q;
    ser_mask = `GYO_RW_SER_IF;
    if (!txn_from_spi_in) begin
      ser_mask = ser_mask & ~`GYO_SPI_WIRE_MASK;
    end
    if (wr) begin
      case (txn_addr_in)
        `GYO_ADDR_DSP3: dsp3_d = merge(dsp3_q, txn_wdata_in,
                                       `GYO_RW_DSP3);
        `GYO_ADDR_RATE_CTRL: rate_ctrl_d = merge(rate_ctrl_q, txn_wdata_in,
                                                 `GYO_RW_RATE_CTRL);
        `GYO_ADDR_TEMP_FMT: begin
          temp_fmt_d = merge(temp_fmt_q, txn_wdata_in,
                             `GYO_RW_TEMP_FMT);
          // Forbidden width code keeps the old width
          if (txn_wdata_in[`GYO_TEMP_WIDTH_HI:`GYO_TEMP_WIDTH_LO] ==
              `GYO_TEMP_WIDTH_BAD) begin
            temp_fmt_d[`GYO_TEMP_WIDTH_HI:`GYO_TEMP_WIDTH_LO] =
              temp_fmt_q[`GYO_TEMP_WIDTH_HI:`GYO_TEMP_WIDTH_LO];
          end
        end
        `GYO_ADDR_SER_IF: begin
          if (!multi_slave_en_in) begin
            ser_if_d = merge(ser_if_q, txn_wdata_in, ser_mask);
          end
        end
        default: ;
      endcase
    end
    if (soft_rst) begin
      dsp3_d = `GYO_RST_DSP3;
      rate_ctrl_d = `GYO_RST_RATE_CTRL;
      temp_fmt_d = `GYO_RST_TEMP_FMT;
      ser_if_d = `GYO_RST_SER_IF;
    end
  end

  // Read data holds until the next read, so a late sample still sees it
  // Unmapped reads give zero rather than a stale byte
  always_comb begin
    rd_data_d = rd_data_q;
    if (rd) begin
      case (txn_addr_in)
        `GYO_ADDR_DSP3: rd_data_d = dsp3_q;
        `GYO_ADDR_RATE_CTRL: rd_data_d = rate_ctrl_q;
        `GYO_ADDR_TEMP_FMT: rd_data_d = temp_fmt_q;
        `GYO_ADDR_SER_IF: rd_data_d = ser_if_q;
        default: rd_data_d = `GYO_BYTE_ZERO;
      endcase
    end
  end

  // Power-on reset lands on the same defaults as the soft reset command
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dsp3_q <= `GYO_RST_DSP3;
      rate_ctrl_q <= `GYO_RST_RATE_CTRL;
      temp_fmt_q <= `GYO_RST_TEMP_FMT;
      ser_if_q <= `GYO_RST_SER_IF;
      rd_data_q <= `GYO_BYTE_ZERO;
    end else begin
      dsp3_q <= dsp3_d;
      rate_ctrl_q <= rate_ctrl_d;
      temp_fmt_q <= temp_fmt_d;
      ser_if_q <= ser_if_d;
      rd_data_q <= rd_data_d;
    end
  end

  // Offset is dropped by a soft reset as enable returns to zero
  gyo_zero_cal u_zero_cal (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .cal_cmd_in(cal_cmd),
    .cal_enable_in(dsp3_q[`GYO_BIT_ZERO_CAL_EN]),
    .cal_variant_in(cal_variant_in),
    .clear_in(soft_rst),
    .raw_rate_in(raw_rate_in),
    .rate_out(rate_out),
    .cal_applied_out(cal_applied_out)
  );

  assign rd_data_out = rd_data_q;
  assign rate_word_width_sel_out = rate_ctrl_q[`GYO_BIT_RATE_WIDTH];
  assign temp_word_width_sel_out =
    temp_fmt_q[`GYO_TEMP_WIDTH_HI:`GYO_TEMP_WIDTH_LO];
  assign sdo_pin_function_sel_out =
    temp_fmt_q[`GYO_SDO_SEL_HI:`GYO_SDO_SEL_LO];
  assign spi_wire_count_sel_out = ser_if_q[`GYO_BIT_SPI_WIRE];
  assign i2c_enable_out = ser_if_q[`GYO_BIT_I2C_EN];
  assign zero_cal_enable_out = dsp3_q[`GYO_BIT_ZERO_CAL_EN];

endmodule

// File: gyo_cfg_regs_sva.sv
// Port assertions for the gyro config bank
`timescale 1ns/1ps
module gyo_cfg_sva (
  input logic clk_in, reset_n_in, txn_valid_in, txn_write_in,
  input logic txn_has_data_in, txn_from_spi_in, multi_slave_en_in,
  input logic cal_variant_in, cal_applied_out, rate_word_width_sel_out,
  input logic spi_wire_count_sel_out, i2c_enable_out, zero_cal_enable_out,
  input logic [7:0] txn_addr_in, txn_wdata_in,
  input logic [1:0] temp_word_width_sel_out, sdo_pin_function_sel_out,
  input logic [23:0] raw_rate_in, rate_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  logic wr, cmd, dflt;
  assign wr = txn_valid_in && txn_write_in && txn_has_data_in;
  assign cmd = txn_valid_in && !txn_has_data_in;
  assign dflt = !rate_word_width_sel_out && !spi_wire_count_sel_out &&
    temp_word_width_sel_out == 2'h2 && sdo_pin_function_sel_out == 2'h2 &&
    i2c_enable_out && !zero_cal_enable_out;
  sequence s_cal;
    cmd && txn_addr_in == 8'h0C && zero_cal_enable_out && cal_variant_in;
  endsequence
  sequence s_apply;
    cal_applied_out ##1
      rate_out == $past(raw_rate_in) - $past(raw_rate_in, 2);
  endsequence
  property p_rate;
    wr && txn_addr_in == 8'h0B |=>
      rate_word_width_sel_out == $past(txn_wdata_in[2]);
  endproperty
  a_rate: assert property (p_rate) else $error("rate width");
  property p_dflt;
    $rose(reset_n_in) |-> dflt;
  endproperty
  a_dflt: assert property (p_dflt) else $error("reset values");
  property p_tbad;
    wr && txn_addr_in == 8'h1C && txn_wdata_in[6:5] == 2'h3 |=>
      $stable(temp_word_width_sel_out);
  endproperty
  a_tbad: assert property (p_tbad) else $error("temp width 11");
  property p_i2c;
    wr && txn_addr_in == 8'h1F && !txn_from_spi_in && !multi_slave_en_in
      |=> $stable(spi_wire_count_sel_out) &&
      i2c_enable_out == $past(txn_wdata_in[0]);
  endproperty
  a_i2c: assert property (p_i2c) else $error("i2c write");
  property p_multi;
    wr && txn_addr_in == 8'h1F && multi_slave_en_in |=>
      $stable(spi_wire_count_sel_out) && $stable(i2c_enable_out);
  endproperty
  a_multi: assert property (p_multi) else $error("multi slave");
  property p_srst;
    cmd && txn_addr_in == 8'h09 |=> dflt && !cal_applied_out;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset");
  property p_cal;
    s_cal |=> s_apply;
  endproperty
  a_cal: assert property (p_cal) else $error("offset capture");
  property p_base;
    cmd && txn_addr_in == 8'h0C && !cal_variant_in && !cal_applied_out
      |=> !cal_applied_out;
  endproperty
  a_base: assert property (p_base) else $error("base variant");
  property p_off;
    !zero_cal_enable_out |=> rate_out == $past(raw_rate_in);
  endproperty
  a_off: assert property (p_off) else $error("offset not off");
endmodule
bind gyo_cfg_regs gyo_cfg_sva chk_u (.*);

// File: gyo_host.sv
// Host model issuing single-byte transactions
`timescale 1ns/1ps
module gyo_host (
  input wire logic clk_in,
  output logic txn_valid_out, txn_write_out, txn_has_data_out,
  output logic txn_from_spi_out,
  output logic [7:0] txn_addr_out, txn_wdata_out
);
  initial begin
    {txn_valid_out, txn_write_out, txn_has_data_out} = 3'h0;
    {txn_from_spi_out, txn_addr_out, txn_wdata_out} = 17'h00000;
  end
  // Idle address and write data flip so a stale value is never read as fresh
  task xfer(input logic [7:0] a, input logic w, d, s,
    input logic [7:0] v);
    @(posedge clk_in);
    #1;
    txn_valid_out = 1'b1;
    txn_addr_out = a;
    txn_write_out = w;
    txn_has_data_out = d;
    txn_wdata_out = v;
    txn_from_spi_out = s;
    @(posedge clk_in);
    #1;
    txn_valid_out = 1'b0;
    txn_addr_out = ~a;
    txn_wdata_out = ~v;
  endtask
endmodule

// File: gyo_cfg_regs_tb.sv
// Self-checking bench for the gyro config bank
`timescale 1ns/1ps
module gyo_cfg_regs_tb;
  logic clk_in = 1'b0, reset_n_in = 1'b0, multi = 1'b0, var_c = 1'b0;
  logic v, w, d, s, cal_on, rd_pend = 1'b0;
  logic [7:0] a, wd, rd, r, q[$];
  logic [23:0] raw = 24'h000000;
  int mismatches = 0, compares = 0, cyc = 0;
  logic [7:0] adr[5] = '{8'h03, 8'h0B, 8'h1C, 8'h1F, 8'h55};
  logic [7:0] dfv[5] = '{8'h00, 8'h01, 8'h4B, 8'h01, 8'h00};
  gyo_host h (.clk_in(clk_in), .txn_valid_out(v), .txn_write_out(w),
    .txn_has_data_out(d), .txn_from_spi_out(s), .txn_addr_out(a),
    .txn_wdata_out(wd));
  gyo_cfg_regs dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .txn_valid_in(v), .txn_addr_in(a), .txn_write_in(w),
    .txn_has_data_in(d), .txn_wdata_in(wd), .txn_from_spi_in(s),
    .rd_data_out(rd), .multi_slave_en_in(multi), .cal_variant_in(var_c),
    .raw_rate_in(raw), .rate_out(), .cal_applied_out(cal_on),
    .rate_word_width_sel_out(), .temp_word_width_sel_out(),
    .sdo_pin_function_sel_out(), .spi_wire_count_sel_out(),
    .i2c_enable_out(), .zero_cal_enable_out());
  initial forever #50 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    raw <= #1 24'($urandom);
    rd_pend <= v && !w && d;
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      summarize();
    end
  end
  task chk(input string n, input logic [7:0] x, y);
    compares++;
    if (x !== y) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, x, y);
    end
  endtask
  // Read results are compared in order as they appear
  always @(negedge clk_in) if (rd_pend) chk("rd_data_out", q.pop_front(), rd);
  task wr(input logic [7:0] ad, dt, input logic sp = 1'b1);
    h.xfer(ad, 1'b1, 1'b1, sp, dt);
  endtask
  task rdx(input logic [7:0] ad, ex);
    q.push_back(ex);
    h.xfer(ad, 1'b0, 1'b1, 1'b1, 8'h00);
  endtask
  task cm(input logic [7:0] ad);
    h.xfer(ad, 1'b0, 1'b0, 1'b1, 8'h00);
  endtask
  task dflts;
    for (int i = 0; i < 5; i++) rdx(adr[i], dfv[i]);
  endtask
  task summarize;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    void'($urandom(99));
    repeat (3) @(posedge clk_in);
    #1 reset_n_in = 1'b1;
    dflts();
    $display("test defaults done");
    wr(8'h0B, 8'hC5);
    rdx(8'h0B, 8'h05);
    wr(8'h1C, 8'h6B);
    rdx(8'h1C, 8'h4B);
    wr(8'h1C, 8'h37);
    rdx(8'h1C, 8'h37);
    r = 8'($urandom) & 8'h27;
    wr(8'h03, r);
    rdx(8'h03, r);
    $display("test fields done");
    wr(8'h1F, 8'h02, 1'b0);
    rdx(8'h1F, 8'h00);
    wr(8'h1F, 8'h03);
    rdx(8'h1F, 8'h03);
    multi = 1'b1;
    wr(8'h1F, 8'h00);
    rdx(8'h1F, 8'h03);
    multi = 1'b0;
    $display("test serial if done");
    wr(8'h03, 8'h40);
    cm(8'h0C);
    chk("cal_applied_out", 8'h00, {7'h00, cal_on});
    var_c = 1'b1;
    cm(8'h0C);
    chk("cal_applied_out", 8'h01, {7'h00, cal_on});
    wr(8'h03, 8'h00);
    repeat (2) @(posedge clk_in);
    #1 chk("cal_applied_out", 8'h00, {7'h00, cal_on});
    $display("test calibration done");
    wr(8'h03, 8'h40);
    cm(8'h0C);
    wr(8'h0B, 8'h05);
    cm(8'h09);
    chk("cal_applied_out", 8'h00, {7'h00, cal_on});
    dflts();
    $display("test soft reset done");
    summarize();
  end
endmodule
